/* design/fopc_defs.svh */
`ifndef FOPC_DEFS_SVH
`define FOPC_DEFS_SVH
// ----------------------------------------
// apb register byte addresses
// ----------------------------------------
`define FOPC_ADDR_OPTION 12'h000
`define FOPC_ADDR_CONTROL 12'h004
`define FOPC_ADDR_PAGE 12'h008
`define FOPC_ADDR_PTR 12'h00c
`define FOPC_ADDR_CPU 12'h010
`define FOPC_ADDR_CPU_DATA 12'h014
`define FOPC_ADDR_SECURE 12'h018
// ----------------------------------------
// field positions
// ----------------------------------------
`define FOPC_BIT_SECURITY_DISABLE_BIT 0
`define FOPC_BIT_PGM 0
`define FOPC_BIT_MASS 2
`define FOPC_BIT_HIGH_VOLTAGE_ENABLE 3
// ----------------------------------------
// direct page map
// ----------------------------------------
`define FOPC_WIN_BASE 8'hc0
`define FOPC_IND_ADDR 8'h0e
`define FOPC_PTR_ADDR 8'h0f
`define FOPC_RAM_LAST 8'h0e
`define FOPC_PAGE_RST 8'h00
`define FOPC_CTRL_RST 8'h00
`endif

/* design/fopc_pkg.sv */
package fopc_pkg;
    // cpu direct-page access request
    typedef struct packed {
        logic req;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fopc_cpu_req_type;

    // flash array port toward the nonvolatile store
    typedef struct packed {
        logic req;
        logic wr;
        logic [13:0] addr;
        logic [7:0] wdata;
    } fopc_mem_req_type;

    typedef enum logic [1:0] {
        FOPC_LOAD,
        FOPC_RUN
    } fopc_state_type;
endpackage

/* design/fopc_top.sv */
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "fopc_defs.svh"
// Summary of operation
// - every reset reloads the option shadow from the nonvolatile option byte
// - option shadow bits 7..1 always read zero
// - option shadow readable anytime, writes ignored
// - option bit 0 low means secured, high means unsecured
// - secured: unsecured sources get zero from flash, no flash reach
// - high voltage bit sets only with program or mass select
// - control bit 2 selects mass erase
// - control bit 0 selects programming
// - program and mass select never both one
// - secured: writes to program select are ignored
// - window c0..ff redirected to page-selected 64-byte block
// - page select gives address bits 13..6, offset bits 5..0
// - ram 00..0e, pointer at 0f, indirect data decoded only at 0e
// - page zero: window c0..ce is ram, cf is pointer
// - indirect reaches ram 0e when pointer is 0e, or ce at page zero
module fopc_top (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // nonvolatile option byte
    input wire logic [7:0] nonvolatile_option_byte,
    // flash array
    output fopc_pkg::fopc_mem_req_type flash_req,
    input wire logic [7:0] flash_rdata,
    // flash control outputs
    output logic program_select,
    output logic mass_erase_select,
    output logic high_voltage_enable,
    output logic security_engaged
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    fopc_pkg::fopc_state_type state_ff;
    logic [7:0] option_ff;
    logic [7:0] control_ff;
    logic [7:0] page_ff;
    logic [7:0] ptr_ff;
    logic [7:0] ram_ff [0:14];
    logic [7:0] cpu_data_ff;
    logic [7:0] prdata_ff;
    logic secure_src_ff;
    fopc_pkg::fopc_cpu_req_type cpu_req;
    logic wr_en;
    logic rd_en;
    logic [7:0] wbyte;
    logic [7:0] nxt_control;
    logic [13:0] phys;
    logic cpu_go;

    assign wr_en = psel & penable & pwrite & (state_ff == fopc_pkg::FOPC_RUN);
    assign rd_en = psel & penable & ~pwrite & (state_ff == fopc_pkg::FOPC_RUN);
    assign wbyte = pwdata[7:0];
    // hold off the bus until the option byte is in
    assign pready = (state_ff == fopc_pkg::FOPC_RUN);
    assign pslverr = 1'b0;
    assign security_engaged = ~option_ff[`FOPC_BIT_SECURITY_DISABLE_BIT];
    assign program_select = control_ff[`FOPC_BIT_PGM];
    assign mass_erase_select = control_ff[`FOPC_BIT_MASS];
    assign high_voltage_enable = control_ff[`FOPC_BIT_HIGH_VOLTAGE_ENABLE];

    // ----------------------------------------
    // direct page translation
    // ----------------------------------------
    function automatic logic [13:0] map_addr(input logic [7:0] a, input logic [7:0] pg);
        if (a >= `FOPC_WIN_BASE) begin
            map_addr = {pg, a[5:0]};
        end else begin
            map_addr = {6'h00, a};
        end
    endfunction

    // redirect: indirect register only at the bare address, never via window
    function automatic logic [13:0] resolve(input logic [7:0] a, input logic [7:0] pg,
            input logic [7:0] ptr);
        if (a == `FOPC_IND_ADDR) begin
            resolve = map_addr(ptr, pg);
        end else begin
            resolve = map_addr(a, pg);
        end
    endfunction

    // physical decode shared by the write, read and flash paths
    function automatic logic is_ram(input logic [13:0] p);
        is_ram = (p <= {6'h00, `FOPC_RAM_LAST});
    endfunction

    function automatic logic is_ptr(input logic [13:0] p);
        is_ptr = (p == {6'h00, `FOPC_PTR_ADDR});
    endfunction

    assign cpu_req.req = wr_en & (paddr == `FOPC_ADDR_CPU);
    assign cpu_req.wr = wbyte[7];
    assign cpu_req.addr = pwdata[15:8];
    assign cpu_req.wdata = pwdata[23:16];
    assign phys = resolve(cpu_req.addr, page_ff, ptr_ff);
    assign cpu_go = cpu_req.req;

    // ----------------------------------------
    // reset load sequencing
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= fopc_pkg::FOPC_LOAD;
        end else begin
            state_ff <= fopc_pkg::FOPC_RUN;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            option_ff <= 8'h00;
        end else if (state_ff == fopc_pkg::FOPC_LOAD) begin
            // sampled after release, never under the async reset
            option_ff <= {7'h00, nonvolatile_option_byte[`FOPC_BIT_SECURITY_DISABLE_BIT]};
        end
        // no write path: writes leave the shadow alone
    end

    // ----------------------------------------
    // flash control interlocks
    // ----------------------------------------
    always_comb begin
        nxt_control = control_ff;
        if (wr_en && paddr == `FOPC_ADDR_CONTROL) begin
            nxt_control[`FOPC_BIT_MASS] = wbyte[`FOPC_BIT_MASS];
            if (!security_engaged) begin
                nxt_control[`FOPC_BIT_PGM] = wbyte[`FOPC_BIT_PGM];
            end
            // both requested at once: neither is taken
            if (nxt_control[`FOPC_BIT_PGM] && nxt_control[`FOPC_BIT_MASS]) begin
                nxt_control[`FOPC_BIT_PGM] = control_ff[`FOPC_BIT_PGM];
                nxt_control[`FOPC_BIT_MASS] = control_ff[`FOPC_BIT_MASS];
            end
            if (wbyte[`FOPC_BIT_HIGH_VOLTAGE_ENABLE] &&
                    !(nxt_control[`FOPC_BIT_PGM] || nxt_control[`FOPC_BIT_MASS])) begin
                nxt_control[`FOPC_BIT_HIGH_VOLTAGE_ENABLE] = control_ff[`FOPC_BIT_HIGH_VOLTAGE_ENABLE];
            end else begin
                nxt_control[`FOPC_BIT_HIGH_VOLTAGE_ENABLE] = wbyte[`FOPC_BIT_HIGH_VOLTAGE_ENABLE];
            end
        end
        nxt_control[7:4] = 4'h0;
        nxt_control[1] = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_ff <= `FOPC_CTRL_RST;
        end else begin
            control_ff <= nxt_control;
        end
    end

    // ----------------------------------------
    // page select and pointer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_ff <= `FOPC_PAGE_RST;
        end else if (wr_en && paddr == `FOPC_ADDR_PAGE) begin
            page_ff <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_ff <= 8'h00;
        end else if (wr_en && paddr == `FOPC_ADDR_PTR) begin
            ptr_ff <= wbyte;
        end else if (cpu_go && cpu_req.wr && is_ptr(phys)) begin
            ptr_ff <= cpu_req.wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secure_src_ff <= 1'b0;
        end else if (wr_en && paddr == `FOPC_ADDR_SECURE) begin
            secure_src_ff <= wbyte[0];
        end
    end

    // ----------------------------------------
    // ram and cpu access
    // ----------------------------------------
    // ram keeps its contents over reset, as real sram does
    always_ff @(posedge pclk) begin
        if (cpu_go && cpu_req.wr && is_ram(phys)) begin
            ram_ff[phys[3:0]] <= cpu_req.wdata;
        end
    end

    // flash request: blocked for unsecured source while secured
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_req <= '0;
        end else begin
            flash_req.req <= cpu_go && !is_ram(phys) && !is_ptr(phys) &&
                !(security_engaged && !secure_src_ff);
            flash_req.wr <= cpu_req.wr;
            flash_req.addr <= phys;
            flash_req.wdata <= cpu_req.wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_data_ff <= 8'h00;
        end else if (cpu_go && !cpu_req.wr) begin
            if (is_ram(phys)) begin
                cpu_data_ff <= ram_ff[phys[3:0]];
            end else if (is_ptr(phys)) begin
                cpu_data_ff <= ptr_ff;
            end else begin
                cpu_data_ff <= 8'h00;
            end
        end else if (flash_req.req && !flash_req.wr) begin
            cpu_data_ff <= flash_rdata;
        end else if (cpu_go && security_engaged && !secure_src_ff) begin
            cpu_data_ff <= 8'h00;
        end
    end

    // ----------------------------------------
    // apb read data
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 8'h00;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `FOPC_ADDR_OPTION: prdata_ff <= option_ff;
                `FOPC_ADDR_CONTROL: prdata_ff <= control_ff;
                `FOPC_ADDR_PAGE: prdata_ff <= page_ff;
                `FOPC_ADDR_PTR: prdata_ff <= ptr_ff;
                `FOPC_ADDR_CPU_DATA: prdata_ff <= cpu_data_ff;
                `FOPC_ADDR_SECURE: prdata_ff <= {7'h00, secure_src_ff};
                default: prdata_ff <= 8'h00;
            endcase
        end
    end

    assign prdata = {24'h000000, prdata_ff};
    logic unused_rd;
    assign unused_rd = rd_en;
endmodule

/* verif/fopc_flash_model.sv */
`timescale 1ns/100ps
module fopc_flash_model (
    // flash port
    input wire logic pclk,
    input wire fopc_pkg::fopc_mem_req_type flash_req,
    output logic [7:0] flash_rdata
);
    logic [7:0] mem [16384];
    logic [7:0] idle;
    initial begin
        idle = 8'h5a;
        for (int i = 0; i < 16384; i++) mem[i] = i[7:0] ^ 8'h3c;
    end
    // idle bus moves every cycle so stale data cannot pass
    always @(posedge pclk) begin
        idle <= idle + 8'h35;
        if (flash_req.req && flash_req.wr) mem[flash_req.addr] <= flash_req.wdata;
    end
    assign flash_rdata = (flash_req.req && !flash_req.wr) ? mem[flash_req.addr] : idle;
endmodule

/* verif/fopc_top_sva.sv */
`timescale 1ns/100ps
`include "fopc_defs.svh"
module fopc_top_sva (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // flash side
    input wire fopc_pkg::fopc_mem_req_type flash_req,
    input wire logic program_select,
    input wire logic mass_erase_select,
    input wire logic high_voltage_enable,
    input wire logic security_engaged
);
    // ----
    // checks
    // ----
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    assign acc = psel && penable && pready;
    a_sel_exclusive: assert property (!(program_select && mass_erase_select))
        else $error("program and mass select both high");
    a_hv_needs_sel: assert property ($rose(high_voltage_enable) |->
        program_select || mass_erase_select)
        else $error("high voltage set without a select");
    a_no_pgm_secured: assert property (security_engaged |-> !$rose(program_select))
        else $error("program select rose while secured");
    a_option_stable: assert property (pready && $past(pready) |-> $stable(security_engaged))
        else $error("security state changed outside reset");
    a_option_write: assert property (acc && pwrite && paddr == `FOPC_ADDR_OPTION |=>
        $stable(security_engaged))
        else $error("option write took effect");
    a_option_read: assert property (acc && !pwrite && paddr == `FOPC_ADDR_OPTION |->
        prdata == {31'h0, !security_engaged})
        else $error("option read value wrong");
    a_ctrl_read: assert property (acc && !pwrite && paddr == `FOPC_ADDR_CONTROL |->
        prdata == {28'h0, high_voltage_enable, mass_erase_select, 1'b0, program_select})
        else $error("control read disagrees with outputs");
    a_flash_pulse: assert property (flash_req.req |=> !flash_req.req)
        else $error("flash request longer than one cycle");
endmodule
bind fopc_top fopc_top_sva fopc_top_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .flash_req(flash_req), .program_select(program_select),
    .mass_erase_select(mass_erase_select), .high_voltage_enable(high_voltage_enable),
    .security_engaged(security_engaged));

/* verif/testbench.sv */
`timescale 1ns/100ps
`include "fopc_defs.svh"
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic program_select, mass_erase_select, high_voltage_enable, security_engaged;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] nonvolatile_option_byte, flash_rdata;
    fopc_pkg::fopc_mem_req_type flash_req;
    int miscompares = 0;
    int n_checks = 0;
    logic [7:0] cw [8] = '{8'h05, 8'h08, 8'h01, 8'h09, 8'h04, 8'h05, 8'h0c, 8'h00};
    logic [7:0] ce [8] = '{8'h00, 8'h00, 8'h01, 8'h09, 8'h04, 8'h04, 8'h0c, 8'h00};
    logic [7:0] pg [3] = '{8'h01, 8'h10, 8'hff};
    fopc_top fopc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nonvolatile_option_byte(nonvolatile_option_byte),
        .flash_req(flash_req), .flash_rdata(flash_rdata), .program_select(program_select),
        .mass_erase_select(mass_erase_select), .high_voltage_enable(high_voltage_enable),
        .security_engaged(security_engaged));
    fopc_flash_model fopc_flash_model_inst (.pclk(pclk), .flash_req(flash_req),
        .flash_rdata(flash_rdata));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // command word: write flag, direct-page address, data
    task automatic cpu(input logic w, input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, `FOPC_ADDR_CPU, {8'h00, d, a, w, 7'h00});
    endtask
    task automatic cpurd(input logic [7:0] a, input logic [7:0] e);
        cpu(1'b0, a, 8'h00);
        rdchk(`FOPC_ADDR_CPU_DATA, {24'h0, e});
    endtask
    task automatic reset_dut(input logic [7:0] opt);
        @(posedge pclk);
        presetn <= 1'b0;
        nonvolatile_option_byte <= opt;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        nonvolatile_option_byte = 8'hfe;
        reset_dut(8'hfe);
        rdchk(`FOPC_ADDR_OPTION, 32'h0);
        chk({31'h0, security_engaged}, 32'h1);
        xfer(1'b1, `FOPC_ADDR_OPTION, 32'hff);
        rdchk(`FOPC_ADDR_OPTION, 32'h0);
        xfer(1'b1, `FOPC_ADDR_CONTROL, 32'h01);
        rdchk(`FOPC_ADDR_CONTROL, 32'h0);
        xfer(1'b1, `FOPC_ADDR_PAGE, 32'h10);
        cpurd(8'hc3, 8'h00);
        xfer(1'b1, `FOPC_ADDR_SECURE, 32'h01);
        cpurd(8'hc3, 8'h3f);
        $display("test secured done");
        reset_dut(8'h01);
        rdchk(`FOPC_ADDR_OPTION, 32'h1);
        chk({31'h0, security_engaged}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, `FOPC_ADDR_CONTROL, {24'h0, cw[i]});
            rdchk(`FOPC_ADDR_CONTROL, {24'h0, ce[i]});
        end
        $display("test control done");
        xfer(1'b1, `FOPC_ADDR_PAGE, 32'h00);
        cpu(1'b1, 8'hc5, 8'h77);
        cpurd(8'h05, 8'h77);
        cpu(1'b1, 8'hce, 8'h99);
        cpurd(8'hce, 8'h99);
        xfer(1'b1, `FOPC_ADDR_PTR, 32'h0e);
        cpurd(8'hcf, 8'h0e);
        cpurd(8'h0e, 8'h99);
        xfer(1'b1, `FOPC_ADDR_PTR, 32'hce);
        cpurd(8'h0e, 8'h99);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, `FOPC_ADDR_PAGE, {24'h0, pg[i]});
            rdchk(`FOPC_ADDR_PAGE, {24'h0, pg[i]});
            cpurd(8'hc7, {pg[i][1:0], 6'h07} ^ 8'h3c);
        end
        $display("test window done");
        finish_test;
    end
    initial begin
        #1000000;
        miscompares++;
        finish_test;
    end
endmodule
